// ### rom_port_pkg.sv
/*
 * Shared constants and carrier types for the serial boot-ROM port pins.
 * Assumes a single 10 MHz system clock and an asynchronous active-high reset.
 */
package rom_port_pkg;
	// ==========================================
	// Clocking
	// ==========================================
	localparam int unsigned CLK_HZ          = 10_000_000;  // System clock rate
	localparam int unsigned ROM_SLOW_HZ     = 30_000_000;  // Deprecated strap-0 speed
	localparam int unsigned ROM_FAST_HZ     = 60_000_000;  // Strap-1 speed
	// Half-period counts in system cycles; clamp to one cycle at least
	localparam int unsigned SLOW_HALF_RAW   = CLK_HZ / (2 * ROM_SLOW_HZ);
	localparam int unsigned FAST_HALF_RAW   = CLK_HZ / (2 * ROM_FAST_HZ);
	// Slow setting keeps the fast-to-slow ratio even when both clamp
	localparam logic [7:0]  SLOW_HALF       = 8'(FAST_HALF * (ROM_FAST_HZ / ROM_SLOW_HZ));
	localparam logic [7:0]  FAST_HALF       = (FAST_HALF_RAW < 1) ? 8'h01 : 8'(FAST_HALF_RAW);
	// Least reset pulse, in ns, and as cycles
	localparam int unsigned RESET_MIN_NS    = 1000;
	localparam int unsigned RESET_MIN_CYC   = (RESET_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic        STRAP_RESET     = 1'b0;        // Strap value held in reset
	localparam int unsigned BYTE_W          = 8;           // Bits per transfer

	// ==========================================
	// Carriers
	// ==========================================
	typedef struct packed {
		logic o;   // Output level
		logic oe;  // Output enable, high while driving
	} pin_drive_t;

	typedef enum logic [1:0] {
		ROM_MODE_SERIAL,
		ROM_MODE_EEPROM,
		ROM_MODE_OFF
	} rom_mode_t;
endpackage : rom_port_pkg

// ### rom_clk_div.sv
/*
 * Divider producing a one-cycle enable pulse every half period.
 * Assumes the half-period count is at least one.
 */
`timescale 1ns/1ps
module rom_clk_div (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// Control
	input  wire logic       i_run,
	input  wire logic [7:0] i_half,
	// Tick
	output logic            o_tick
);
	// ==========================================
	// Counter
	// ==========================================
	logic [7:0] count;       // Cycles into the half period
	wire        wrap = (count + 8'h01 >= i_half);

	// Count while running, restart otherwise
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			count <= 8'h00;
		end else if (!i_run || wrap) begin
			count <= 8'h00;
		end else begin
			count <= count + 8'h01;
		end
	end

	assign o_tick = i_run && wrap;
endmodule : rom_clk_div

// ### rom_port_pins.sv
/*
 * Serial boot-ROM port pin logic: chip enable, clock, data out with speed
 * strap, data in, two-wire EEPROM alternate use, reset and suspend states.
 * Assumes a user-side byte request interface on the same clock, and pins
 * driven through external pads from the separate output, enable, pull-down and input ports below.
 */
// How it works
// - Select low only while addressing ROM
// - Select high in every power-down state
// - Device drives ROM clock as master
// - ROM clock low during reset
// - Clock pin becomes EEPROM clock alternative
// - Data-out pin sends serial data
// - Data-out pin becomes bidirectional EEPROM data
// - Data-in pin receives ROM data
// - Data-out floats with pull-down in reset
// - Strap level latched at reset release
// - Then data-out function returns, pull-down off
// - Strap picks 30 or 60 MHz clock; the divider gives 2.5 or 5 MHz from the 10 MHz system clock
// - Strap 1: data-out floats in suspend
// - Strap 0: data-out low in suspend
`timescale 1ns/1ps
module rom_port_pins (
	// Clock and reset
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	// Chip state
	input  wire logic                   i_suspend,
	input  wire logic                   i_power_down,
	input  wire logic                   i_eeprom_mode,
	// Byte request
	input  wire logic                   i_start,
	input  wire logic [7:0]             i_tx_byte,
	output logic                        o_busy,
	output logic                        o_done,
	output logic [7:0]                  o_rx_byte,
	output logic                        o_rom_speed_strap,
	// EEPROM alternate drive from the two-wire engine
	input  wire rom_port_pkg::pin_drive_t i_eeprom_clock_alt,
	input  wire rom_port_pkg::pin_drive_t i_eeprom_data_alt,
	output logic                        o_eeprom_data_in,
	// Pins
	output logic                        o_rom_sel_n,
	output logic                        o_rom_clk,
	output logic                        o_rom_clk_oe,
	input  wire logic                   i_rom_clk,
	output logic                        o_rom_dout,
	output logic                        o_rom_dout_oe,
	output logic                        o_rom_dout_pd,
	input  wire logic                   i_rom_dout,
	input  wire logic                   i_rom_data_in
);
	// ==========================================
	// Pin synchronisers
	// ==========================================
	logic [1:0] sync_dout;   // Data-out pin level
	logic [1:0] sync_din;    // Data-in pin level

	// Two flops before any logic reads a pin
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sync_dout <= 2'h0;
			sync_din  <= 2'h0;
		end else begin
			sync_dout <= {sync_dout[0], i_rom_dout};
			sync_din  <= {sync_din[0], i_rom_data_in};
		end
	end

	// ==========================================
	// Strap capture
	// ==========================================
	logic strap;             // Latched speed strap
	logic strap_taken;       // Capture done since reset
	logic [1:0] settle;      // Cycles after release, as a thermometer

	// Sample the pin once it has crossed both cleared flops, then hold
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			strap       <= rom_port_pkg::STRAP_RESET;
			settle      <= 2'h0;
			strap_taken <= 1'b0;
		end else begin
			settle <= {settle[0], 1'b1};
			if (settle[1] && !strap_taken) begin
				strap       <= sync_dout[1];
				strap_taken <= 1'b1;
			end
		end
	end
	assign o_rom_speed_strap = strap;

	// ==========================================
	// Clock divider
	// ==========================================
	typedef enum {S_IDLE, S_SHIFT, S_END} state_t;
	state_t     state;
	logic [2:0] bit_cnt;     // Bits remaining minus one
	logic [7:0] tx_sh;       // Outgoing shift register
	logic [7:0] rx_sh;       // Incoming shift register
	logic       sclk;        // Serial clock level
	logic       tick;        // Half-period enable
	logic [1:0] samp_d;      // Pending data-in samples, two cycles deep

	wire        run      = (state == S_SHIFT);
	wire  [7:0] half_sel = strap ? rom_port_pkg::FAST_HALF : rom_port_pkg::SLOW_HALF;

	rom_clk_div u_div (
		.i_clk  (i_clk),
		.i_rst  (i_rst),
		.i_run  (run),
		.i_half (half_sel),
		.o_tick (tick)
	);

	// ==========================================
	// Byte engine, mode 0, MSB first
	// ==========================================
	wire can_start = i_start && strap_taken && !i_eeprom_mode && !i_power_down && !i_suspend;

	// Data-in arrives two cycles late through its synchroniser, so each
	// rising-clock sample is taken from a two-stage pending line
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			samp_d <= 2'h0;
			rx_sh  <= 8'h00;
		end else begin
			samp_d <= {samp_d[0], run && tick && !sclk};
			if (samp_d[1]) begin
				rx_sh <= {rx_sh[6:0], sync_din[1]};
			end
		end
	end

	// Shift on falling edge, sample on rising edge
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state     <= S_IDLE;
			bit_cnt   <= 3'h0;
			tx_sh     <= 8'h00;
			sclk      <= 1'b0;
			o_done    <= 1'b0;
			o_rx_byte <= 8'h00;
		end else begin
			o_done <= 1'b0;
			unique case (state)
				S_IDLE: begin
					sclk <= 1'b0;
					if (can_start) begin
						tx_sh   <= i_tx_byte;
						bit_cnt <= 3'h7;
						state   <= S_SHIFT;
					end
				end
				S_SHIFT: begin
					if (tick) begin
						sclk <= !sclk;
						if (sclk && bit_cnt == 3'h0) begin
							state <= S_END;
						end else if (sclk) begin
							tx_sh   <= {tx_sh[6:0], 1'b0};
							bit_cnt <= bit_cnt - 3'h1;
						end
					end
				end
				S_END: begin
					// Wait for the last sample to leave the pending line
					if (samp_d == 2'h0) begin
						o_rx_byte <= rx_sh;
						o_done    <= 1'b1;
						state     <= S_IDLE;
					end
				end
			endcase
		end
	end
	assign o_busy = (state != S_IDLE);

	// ==========================================
	// Pin muxing
	// ==========================================
	wire serial_on = strap_taken && !i_eeprom_mode;
	wire parked    = i_suspend || i_power_down;

	// Select low only during a serial transfer
	assign o_rom_sel_n = !(serial_on && !parked && state != S_IDLE);

	// Clock pin: low in reset, serial clock, or EEPROM alternate
	assign o_rom_clk    = !i_rst && (i_eeprom_mode ? i_eeprom_clock_alt.o : sclk);
	assign o_rom_clk_oe = i_rst || (i_eeprom_mode ? i_eeprom_clock_alt.oe : 1'b1);

	// Data-out pin: strap input, suspend state, data, or EEPROM data
	assign o_rom_dout    = (!strap_taken || parked) ? 1'b0
	                     : i_eeprom_mode ? i_eeprom_data_alt.o : tx_sh[7];
	assign o_rom_dout_oe = !strap_taken ? 1'b0
	                     : parked ? !strap
	                     : i_eeprom_mode ? i_eeprom_data_alt.oe : 1'b1;
	assign o_rom_dout_pd = !strap_taken;
	assign o_eeprom_data_in = sync_dout[1];

	// ==========================================
	// Assertions
	// ==========================================
	logic [7:0] hold;        // Cycles the serial clock has held its level

	// Count shifting cycles since the last clock move
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			hold <= 8'h01;
		end else if (!run || tick) begin
			hold <= 8'h01;
		end else begin
			hold <= hold + 8'h01;
		end
	end

	strap_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
		strap_taken && $past(strap_taken) |-> $stable(strap)) else $error("strap changed");
	strap_take_a: assert property (@(posedge i_clk) disable iff (i_rst)
		settle[1] && !strap_taken |=> strap == $past(sync_dout[1])) else $error("strap not captured");
	sel_park_a: assert property (@(posedge i_clk) disable iff (i_rst)
		parked |-> o_rom_sel_n) else $error("select low while parked");
	sel_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
		state == S_IDLE |-> o_rom_sel_n) else $error("select low while idle");
	float_reset_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!strap_taken |-> !o_rom_dout_oe && o_rom_dout_pd) else $error("strap pin driven");
	pd_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
		strap_taken |-> !o_rom_dout_pd) else $error("pull-down left on");
	susp_float_a: assert property (@(posedge i_clk) disable iff (i_rst)
		strap_taken && i_suspend && strap |-> !o_rom_dout_oe) else $error("pin driven in suspend");
	susp_low_a: assert property (@(posedge i_clk) disable iff (i_rst)
		strap_taken && i_suspend && !strap |-> o_rom_dout_oe && !o_rom_dout) else $error("pin not low");
	clk_speed_a: assert property (@(posedge i_clk) disable iff (i_rst)
		run && tick |-> hold == (strap ? rom_port_pkg::FAST_HALF : rom_port_pkg::SLOW_HALF)) else $error("speed wrong");
	byte_len_a: assert property (@(posedge i_clk) disable iff (i_rst)
		state == S_IDLE && can_start |=> o_busy [*8]) else $error("transfer too short");
endmodule : rom_port_pins

// ### rom_serial_model.sv
/*
 * Behavioural serial ROM that answers one byte per select, top bit first.
 * Assumes the host shifts on falling clock and samples on rising clock.
 */
`timescale 1ns/1ps
module rom_serial_model (
	// Pins seen from the ROM
	input  wire logic       i_sel_n,
	input  wire logic       i_sclk,
	input  wire logic       i_mosi,
	// Bench side
	input  wire logic [7:0] i_reply,
	output logic            o_miso,
	output logic [7:0]      o_got
);
	logic [7:0] sh;  // Outgoing shift register
	// ==========================================
	// Shifting
	// ==========================================
	// Present the top bit as soon as selected
	always @(negedge i_sel_n) begin
		sh = i_reply;
		o_miso = i_reply[7];
	end
	// Capture host data on rising clock
	always @(posedge i_sclk) if (!i_sel_n) o_got = {o_got[6:0], i_mosi};
	// Next bit after each falling clock
	always @(negedge i_sclk) if (!i_sel_n) begin
		sh = {sh[6:0], 1'b0};
		o_miso = sh[7];
	end
	// Released line shows the inverse of its last level
	always @(posedge i_sel_n) o_miso = ~o_miso;
endmodule : rom_serial_model

// ### boot_rom_serial_port_pins_test.sv
/*
 * Self-checking bench for the serial boot-ROM pins: reset, strap, transfers,
 * suspend, power-down and two-wire alternate use.
 * Assumes the ROM model file is compiled first.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
	$display("unexpected at %0t: got %0h want %0h", $time, (a), (b)); end end
module boot_rom_serial_port_pins_test;
	logic                     i_clk = 1'b0, i_rst = 1'b1;
	logic                     i_suspend = 1'b0, i_power_down = 1'b0, i_eeprom_mode = 1'b0;
	logic                     i_start = 1'b0, strap_up = 1'b0;
	logic [7:0]               i_tx_byte = 8'h00, reply = 8'h00, got, o_rx_byte;
	rom_port_pkg::pin_drive_t ck_alt = '0, dt_alt = '0;
	logic                     o_busy, o_done, strap, ee_in, sel_n, sclk, sclk_oe, dout, dout_oe, pd, miso;
	wire                      dpin = dout_oe ? dout : strap_up;  // External strap resistor wins the pull-down
	int                       num_errors = 0, n_checks = 0, hi = 0, cyc = 0, s, k;
	int                       seed = 32'heef6;
	logic [7:0]               exp_q[$];  // Expected replies
	// ==========================================
	// Clock, timeout and clock-high counter
	// ==========================================
	initial forever #50 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc++;
		if (sclk === 1'b1) hi++;
		if (cyc == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end
	rom_port_pins rom_port_pins_inst (.i_clk(i_clk), .i_rst(i_rst), .i_suspend(i_suspend),
		.i_power_down(i_power_down), .i_eeprom_mode(i_eeprom_mode), .i_start(i_start),
		.i_tx_byte(i_tx_byte), .o_busy(o_busy), .o_done(o_done), .o_rx_byte(o_rx_byte),
		.o_rom_speed_strap(strap), .i_eeprom_clock_alt(ck_alt), .i_eeprom_data_alt(dt_alt),
		.o_eeprom_data_in(ee_in), .o_rom_sel_n(sel_n), .o_rom_clk(sclk), .o_rom_clk_oe(sclk_oe),
		.i_rom_clk(sclk_oe ? sclk : 1'b1), .o_rom_dout(dout), .o_rom_dout_oe(dout_oe),
		.o_rom_dout_pd(pd), .i_rom_dout(dpin), .i_rom_data_in(miso));
	rom_serial_model rom_serial_model_inst (.i_sel_n(sel_n), .i_sclk(sclk), .i_mosi(dpin),
		.i_reply(reply), .o_miso(miso), .o_got(got));
	// ==========================================
	// Tasks
	// ==========================================
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	// Reset long enough, check pin states inside it
	task automatic do_reset();
		@(posedge i_clk) i_rst <= 1'b1;
		repeat (16) @(posedge i_clk);
		`CHK({sel_n, sclk, sclk_oe}, 3'b101)
		`CHK({dout_oe, pd, strap}, 3'b010)
		i_rst <= 1'b0;
		repeat (4) @(posedge i_clk);
		#1;
	endtask : do_reset
	// One byte each way, started after the previous one has finished
	task automatic xfer(input logic [7:0] tx);
		logic [7:0] rp;
		rp = 8'($random(seed));
		@(posedge i_clk);
		reply = rp;
		exp_q.push_back(rp);
		hi = 0;
		i_start <= 1'b1;
		i_tx_byte <= tx;
		@(posedge i_clk) i_start <= 1'b0;
		#1;
		`CHK({o_busy, sel_n}, 2'b10)
		for (k = 0; k < 200 && o_done !== 1'b1; k++) begin
			@(posedge i_clk);
			#1;
		end
		`CHK(o_done, 1'b1)
		`CHK({o_busy, sel_n}, 2'b01)
		`CHK(o_rx_byte, exp_q.pop_front())
		`CHK(got, tx)
		`CHK(hi, 8 * int'(s[0] ? rom_port_pkg::FAST_HALF : rom_port_pkg::SLOW_HALF))
	endtask : xfer
	// ==========================================
	// Main sequence
	// ==========================================
	initial begin
		for (s = 0; s < 2; s++) begin
			strap_up = s[0];
			do_reset();
			`CHK({strap, pd}, {s[0], 1'b0})
			strap_up = ~s[0];
			repeat (4) xfer(8'($random(seed)));
			`CHK(strap, s[0])
			@(posedge i_clk) i_suspend <= 1'b1;
			repeat (3) @(posedge i_clk);
			#1;
			`CHK({dout_oe, dout_oe ? dout : 1'b0}, {~s[0], 1'b0})
			`CHK(sel_n, 1'b1)
			@(posedge i_clk);
			i_suspend <= 1'b0;
			i_power_down <= 1'b1;
			repeat (3) @(posedge i_clk);
			#1;
			`CHK(sel_n, 1'b1)
			@(posedge i_clk) i_power_down <= 1'b0;
		end
		@(posedge i_clk) i_eeprom_mode <= 1'b1;
		repeat (8) begin
			@(posedge i_clk) {ck_alt, dt_alt} <= 4'($random(seed));
			repeat (3) @(posedge i_clk);
			#1;
			`CHK({sclk, sclk_oe}, ck_alt)
			`CHK({dout, dout_oe, ee_in}, {dt_alt, dpin})
		end
		report_and_stop();
	end
endmodule : boot_rom_serial_port_pins_test
